// ---- core/tmf_pkg.sv ----
/*
 * tmf_pkg: shared constants and types for the timer channel status block.
 * assumes a 32-bit apb slave with byte addresses on word boundaries.
 */
package tmf_pkg;
  // register byte offsets
  localparam logic [7:0] TMF_OFF_STATUS = 8'h00;
  localparam logic [7:0] TMF_OFF_CTRL = 8'h04;
  localparam logic [7:0] TMF_OFF_COUNT = 8'h08;
  localparam logic [7:0] TMF_OFF_UPPER = 8'h0C;
  localparam logic [7:0] TMF_OFF_LOWER = 8'h10;
  localparam logic [7:0] TMF_OFF_CAPTURE = 8'h14;
  localparam logic [7:0] TMF_OFF_MASK = 8'h18;

  // status register bit positions
  localparam int TMF_BIT_WRAP = 7;
  localparam int TMF_BIT_ABOVE = 6;
  localparam int TMF_BIT_EQUAL = 5;
  localparam int TMF_BIT_EDGE = 4;
  localparam int TMF_BIT_CAPT = 3;
  localparam int TMF_BIT_BELOW = 2;
  localparam int TMF_NFLAGS = 5;

  // flags held in the status register, in cell order
  localparam int TMF_FLAG_POS [TMF_NFLAGS] = '{TMF_BIT_WRAP, TMF_BIT_ABOVE,
    TMF_BIT_EQUAL, TMF_BIT_CAPT, TMF_BIT_BELOW};

  // reset values, count maximum and external clock select code
  localparam logic [15:0] TMF_RST_COUNT = 16'h0000;
  localparam logic [15:0] TMF_RST_UPPER = 16'hFFFF;
  localparam logic [15:0] TMF_RST_LOWER = 16'h0000;
  localparam logic [15:0] TMF_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] TMF_RST_BYTE = 8'h00;
  localparam logic [2:0] TMF_CLK_EXT = 3'h7;

  // control register fields, msb to lsb of the low byte
  typedef struct packed {
    logic counter_start;
    logic [1:0] spare;
    logic capture_edge_select;
    logic measure_mode_select;
    logic [2:0] clock_source_select;
  } tmf_ctrl_t;

  // event strobes that set the flags, one cycle each except equal, held in timer mode while the count matches the upper limit
  typedef struct packed {
    logic wrap;
    logic above;
    logic equal;
    logic capt;
    logic below;
  } tmf_events_t;
endpackage : tmf_pkg

// ---- core/tmf_edge_det.sv ----
/*
 * tmf_edge_det: one-cycle pulse on the selected edge of a pin.
 * assumes the pin is already synchronous to mclk.
 */
`timescale 1ns/100ps
module tmf_edge_det (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin and edge choice, 1 = rising, 0 = falling
  input wire logic pin,
  input wire logic rise_sel,
  // result
  output logic edge_pulse
);
  logic prev_reg;

  // remember last level
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin;
    end
  end

  // pick rising or falling transition
  assign edge_pulse = rise_sel ? (pin & ~prev_reg) : (~pin & prev_reg);
endmodule : tmf_edge_det

// ---- core/tmf_flag_cell.sv ----
/*
 * tmf_flag_cell: one sticky event flag, cleared by read-as-one then
 * write-zero. assumes read and write strobes mark completed transfers.
 */
`timescale 1ns/100ps
module tmf_flag_cell (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // hardware event
  input wire logic set_pulse,
  // software access to the status register
  input wire logic rd_done,
  input wire logic rd_value,
  input wire logic wr_done,
  input wire logic wr_value,
  // flag state
  output logic flag
);
  logic flag_reg;
  logic armed_reg;
  logic clr_ok;

  // clear only after the flag was read as one
  assign clr_ok = wr_done & ~wr_value & armed_reg;
  assign flag = flag_reg;

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      flag_reg <= set_pulse | (flag_reg & ~clr_ok);
      if (rd_done) begin
        armed_reg <= rd_value & flag_reg;
      end else if (wr_done) begin
        armed_reg <= 1'b0;
      end
    end
  end
endmodule : tmf_flag_cell

// ---- core/tmf_channel.sv ----
/*
 * tmf_channel: one timer channel with its status flags, counter, limits,
 * capture and an interrupt output, reached over apb.
 * assumes pins ext_clock_pin and event_input_pin are synchronous to mclk.
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module tmf_channel
  import tmf_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRE_W = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins
  input wire logic ext_clock_pin,
  input wire logic event_input_pin,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [CNT_W-1:0] timer_count_reg;
  logic [CNT_W-1:0] upper_limit_compare_reg;
  logic [CNT_W-1:0] lower_limit_value_reg;
  logic [CNT_W-1:0] capture_value_reg;
  tmf_ctrl_t channel_control_reg;
  logic ext_clock_edge_select_reg;
  logic [7:0] int_mask_reg;
  logic [PRE_W-1:0] prescale_reg;
  logic meas_armed_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic acc_wait;
  logic xfer_done;
  logic wr_done;
  logic rd_done;
  logic hit_status;
  logic hit_ctrl;
  logic hit_count;
  logic hit_upper;
  logic hit_lower;
  logic hit_capture;
  logic hit_mask;
  logic addr_ok;
  logic [31:0] rd_mux;

  // access phase waits one cycle, then completes
  assign acc_wait = psel & penable & ~pready_reg;
  assign xfer_done = psel & penable & pready_reg;
  assign wr_done = xfer_done & pwrite;
  assign rd_done = xfer_done & ~pwrite;

  // address match
  assign hit_status = (paddr == TMF_OFF_STATUS);
  assign hit_ctrl = (paddr == TMF_OFF_CTRL);
  assign hit_count = (paddr == TMF_OFF_COUNT);
  assign hit_upper = (paddr == TMF_OFF_UPPER);
  assign hit_lower = (paddr == TMF_OFF_LOWER);
  assign hit_capture = (paddr == TMF_OFF_CAPTURE);
  assign hit_mask = (paddr == TMF_OFF_MASK);
  assign addr_ok = hit_status | hit_ctrl | hit_count | hit_upper |
                   hit_lower | hit_capture | hit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // status byte and flags
  logic [TMF_NFLAGS-1:0] flag_vec;
  logic [TMF_NFLAGS-1:0] set_vec;
  logic [7:0] status_byte;
  logic [7:0] flag_byte;
  tmf_events_t ev;

  // the event struct packs msb first while the cells run in status
  // byte order from bit 7 down, so each strobe is routed by name
  assign set_vec[0] = ev.wrap;
  assign set_vec[1] = ev.above;
  assign set_vec[2] = ev.equal;
  assign set_vec[3] = ev.capt;
  assign set_vec[4] = ev.below;

  // assemble status byte, unused bits read zero
  // flag_byte holds the event flags only: the edge select is a setting
  // and must never raise the interrupt
  always_comb begin
    flag_byte = TMF_RST_BYTE;
    for (int i = 0; i < TMF_NFLAGS; i++) begin
      flag_byte[TMF_FLAG_POS[i]] = flag_vec[i];
    end
    status_byte = flag_byte;
    status_byte[TMF_BIT_EDGE] = ext_clock_edge_select_reg;
  end

  // one sticky cell per flag
  genvar g;
  generate
    for (g = 0; g < TMF_NFLAGS; g++) begin : g_flag
      tmf_flag_cell u_cell (
        .mclk(mclk),
        .rst(rst),
        .set_pulse(set_vec[g]),
        .rd_done(rd_done & hit_status),
        .rd_value(prdata_reg[TMF_FLAG_POS[g]]),
        .wr_done(wr_done & hit_status),
        .wr_value(pwdata[TMF_FLAG_POS[g]]),
        .flag(flag_vec[g])
      );
    end
  endgenerate

  // read data select
  assign rd_mux =
    hit_status ? {24'h000000, status_byte} :
    hit_ctrl ? {24'h000000, channel_control_reg} :
    hit_count ? {16'h0000, timer_count_reg} :
    hit_upper ? {16'h0000, upper_limit_compare_reg} :
    hit_lower ? {16'h0000, lower_limit_value_reg} :
    hit_capture ? {16'h0000, capture_value_reg} :
    hit_mask ? {24'h000000, int_mask_reg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // mode, edges and count tick
  logic measure_mode;
  logic running;
  logic ext_sel;
  logic ext_edge;
  logic evt_edge;
  logic int_tick;
  logic tick;
  logic wrap_now;
  logic [PRE_W-1:0] pre_mask;

  function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = PRE_W'((1 << sel) - 1);
  endfunction : div_mask

  assign measure_mode = channel_control_reg.measure_mode_select;
  assign running = channel_control_reg.counter_start;
  assign ext_sel = (channel_control_reg.clock_source_select == TMF_CLK_EXT);
  assign pre_mask = div_mask(channel_control_reg.clock_source_select);
  assign int_tick = ((prescale_reg & pre_mask) == pre_mask);
  assign tick = running & (ext_sel ? ext_edge : int_tick);
  assign wrap_now = tick & (timer_count_reg == TMF_COUNT_MAX);

  // external clock, bit 4 picks rising when one
  tmf_edge_det u_ext_edge (
    .mclk(mclk),
    .rst(rst),
    .pin(ext_clock_pin),
    .rise_sel(ext_clock_edge_select_reg),
    .edge_pulse(ext_edge)
  );

  // event input with the capture edge choice
  tmf_edge_det u_evt_edge (
    .mclk(mclk),
    .rst(rst),
    .pin(event_input_pin),
    .rise_sel(channel_control_reg.capture_edge_select),
    .edge_pulse(evt_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // capture decisions
  logic cap_timer;
  logic meas_start;
  logic cap_meas;
  logic cap_now;

  assign cap_timer = running & ~measure_mode & evt_edge;
  assign meas_start = running & measure_mode & evt_edge & ~meas_armed_reg;
  assign cap_meas = running & measure_mode & evt_edge & meas_armed_reg;
  assign cap_now = cap_timer | cap_meas;

  // flag set strobes
  assign ev.wrap = wrap_now;
  assign ev.above = cap_meas &
    (timer_count_reg > upper_limit_compare_reg);
  assign ev.equal = ~measure_mode &
    (timer_count_reg == upper_limit_compare_reg);
  assign ev.capt = cap_now;
  assign ev.below = cap_meas &
    (timer_count_reg < lower_limit_value_reg);

  ////////////////////////////////////////////////////////////////////////////
  // counter and capture
  logic [CNT_W-1:0] count_next;

  // software write, measurement restart, stop clear, or count up
  always_comb begin
    count_next = timer_count_reg;
    if (!running && !measure_mode) begin
      count_next = TMF_RST_COUNT;
    end else if (measure_mode && evt_edge && running) begin
      count_next = TMF_RST_COUNT;
    end else if (tick) begin
      count_next = CNT_W'(timer_count_reg + 1'b1);
    end
    if (wr_done && hit_count && !measure_mode) begin
      count_next = pwdata[CNT_W-1:0];
    end
  end

  // count, capture and measurement phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_count_reg <= TMF_RST_COUNT;
      capture_value_reg <= TMF_RST_COUNT;
      meas_armed_reg <= 1'b0;
      prescale_reg <= '0;
    end else begin
      timer_count_reg <= count_next;
      prescale_reg <= PRE_W'(prescale_reg + 1'b1);
      if (cap_now) begin
        capture_value_reg <= timer_count_reg;
      end
      if (!running || !measure_mode) begin
        meas_armed_reg <= 1'b0;
      end else if (meas_start) begin
        meas_armed_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel_control_reg <= tmf_ctrl_t'(TMF_RST_BYTE);
      ext_clock_edge_select_reg <= 1'b0;
      upper_limit_compare_reg <= TMF_RST_UPPER;
      lower_limit_value_reg <= TMF_RST_LOWER;
      int_mask_reg <= TMF_RST_BYTE;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        channel_control_reg <= tmf_ctrl_t'(pwdata[7:0]);
      end
      if (hit_status) begin
        ext_clock_edge_select_reg <= pwdata[TMF_BIT_EDGE];
      end
      if (hit_upper) begin
        upper_limit_compare_reg <= pwdata[CNT_W-1:0];
      end
      if (hit_lower) begin
        lower_limit_value_reg <= pwdata[CNT_W-1:0];
      end
      if (hit_mask) begin
        int_mask_reg <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer and interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pready_reg <= acc_wait;
      pslverr_reg <= acc_wait & ~addr_ok;
      if (acc_wait && !pwrite) begin
        prdata_reg <= rd_mux;
      end
      irq_reg <= |(flag_byte & int_mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
endmodule : tmf_channel

// ---- testbench/tmf_channel_assertions.sv ----
/* tmf_channel_assertions: port-level checks of the channel block.
   assumes it is bound to tmf_channel and sees only its ports. */
`timescale 1ns/100ps
module tmf_channel_assertions
  import tmf_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PRE_W = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and interrupt
  input wire logic ext_clock_pin,
  input wire logic event_input_pin,
  input wire logic irq
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  // a read answer is on the bus
  wire rd_ans = pready && !pwrite;
  wire unmapped = paddr > TMF_OFF_MASK;
  //////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !pready && !irq && prdata == 32'h0) else $error("reset");
  a_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready unasked");
  a_err_unmapped: assert property (pready && unmapped |-> pslverr)
    else $error("no slverr");
  a_err_mapped: assert property (pready && !unmapped &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad slverr");
  a_err_zero: assert property (rd_ans && pslverr |-> prdata == 32'h0)
    else $error("unmapped data");
  a_status_width: assert property (
    rd_ans && paddr == TMF_OFF_STATUS |-> prdata[31:8] == 24'h0 &&
    prdata[1:0] == 2'h0) else $error("status spare bits");
  a_rdata_stands: assert property ($changed(prdata) |-> rd_ans)
    else $error("prdata moved");
  // main scenarios
  c_slverr: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_capture: cover property (rd_ans && paddr == TMF_OFF_CAPTURE);
endmodule : tmf_channel_assertions
bind tmf_channel tmf_channel_assertions #(.CNT_W(CNT_W), .PRE_W(PRE_W))
  tmf_channel_assertions_inst (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_clock_pin(ext_clock_pin), .event_input_pin(event_input_pin),
  .irq(irq));

// ---- testbench/tmf_pin_model.sv ----
/* tmf_pin_model: external count clock and event input pins.
   assumes the bench calls its tasks; pins move just after mclk rises. */
`timescale 1ns/100ps
module tmf_pin_model (
  // clock
  input wire logic mclk,
  // pins
  output logic ext_clock_pin,
  output logic event_input_pin
);
  //////////////////////////////////////////////////////////////////////
  // both pins idle low; the clock stands still between calls
  initial begin
    ext_clock_pin = 1'b0;
    event_input_pin = 1'b0;
  end
  // toggle the clock pin n times, each level held four cycles
  task automatic clk_toggle(input int n);
    repeat (n) begin
      @(posedge mclk) ext_clock_pin <= ~ext_clock_pin;
      repeat (3) @(posedge mclk);
    end
  endtask : clk_toggle
  // one event period, rising edge first, h cycles per level
  task automatic evt_pulse(input int h);
    @(posedge mclk) event_input_pin <= 1'b1;
    repeat (h) @(posedge mclk);
    event_input_pin <= 1'b0;
    repeat (h) @(posedge mclk);
  endtask : evt_pulse
endmodule : tmf_pin_model

// ---- testbench/tb.sv ----
/* tb: register-level tests of the timer channel status flags.
   assumes tmf_channel and tmf_pin_model; apb master runs on mclk. */
`timescale 1ns/100ps
module tb;
  import tmf_pkg::*;
  logic mclk, rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, irq, ext_clock_pin, event_input_pin, e;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  tmf_channel tmf_channel_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext_clock_pin), .event_input_pin(event_input_pin),
    .irq(irq));
  tmf_pin_model tmf_pin_model_inst (.mclk(mclk),
    .ext_clock_pin(ext_clock_pin), .event_input_pin(event_input_pin));
  //////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // one apb transfer: setup, access until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rdc
  // irq after its registered delay
  task automatic irqc(input logic x);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, {31'h0, x});
  endtask : irqc
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc(TMF_OFF_STATUS, 32'h00);
    rdc(TMF_OFF_UPPER, 32'hFFFF);
    // equal flag held by a stopped count of zero: set beats clear
    wr(TMF_OFF_UPPER, 32'h0000);
    rdc(TMF_OFF_STATUS, 32'h20);
    wr(TMF_OFF_STATUS, 32'h00);
    rdc(TMF_OFF_STATUS, 32'h20);
    // a write of one disarms, so the next zero write clears nothing
    wr(TMF_OFF_STATUS, 32'h20);
    wr(TMF_OFF_UPPER, 32'hFFFF);
    wr(TMF_OFF_STATUS, 32'h00);
    rdc(TMF_OFF_STATUS, 32'h20);
    wr(TMF_OFF_STATUS, 32'hFC);
    rdc(TMF_OFF_STATUS, 32'h30);
    wr(TMF_OFF_STATUS, 32'h10);
    rdc(TMF_OFF_STATUS, 32'h10);
    // wrap from all ones; a stopped timer holds zero, so start first
    wr(TMF_OFF_CTRL, 32'h80);
    wr(TMF_OFF_COUNT, 32'hFFF0);
    repeat (40) @(posedge mclk);
    wr(TMF_OFF_CTRL, 32'h00);
    rdc(TMF_OFF_STATUS, 32'hB0);
    wr(TMF_OFF_MASK, 32'h80);
    irqc(1'b1);
    wr(TMF_OFF_STATUS, 32'h10);
    irqc(1'b0);
    // external clock edges, then a timer mode capture
    wr(TMF_OFF_CTRL, 32'h97);
    tmf_pin_model_inst.clk_toggle(3);
    rdc(TMF_OFF_COUNT, 32'h2);
    wr(TMF_OFF_STATUS, 32'h00);
    tmf_pin_model_inst.clk_toggle(3);
    rdc(TMF_OFF_COUNT, 32'h4);
    tmf_pin_model_inst.evt_pulse(4);
    rdc(TMF_OFF_CAPTURE, 32'h4);
    rdc(TMF_OFF_STATUS, 32'h08);
    // measurement: long period above limit, no equal flag
    wr(TMF_OFF_STATUS, 32'h00);
    wr(TMF_OFF_UPPER, 32'h000A);
    wr(TMF_OFF_CTRL, 32'h98);
    tmf_pin_model_inst.evt_pulse(20);
    tmf_pin_model_inst.evt_pulse(20);
    rdc(TMF_OFF_STATUS, 32'h48);
    // short period below the lower limit
    wr(TMF_OFF_STATUS, 32'h00);
    wr(TMF_OFF_UPPER, 32'hFFFF);
    wr(TMF_OFF_LOWER, 32'h1000);
    tmf_pin_model_inst.evt_pulse(20);
    rdc(TMF_OFF_STATUS, 32'h0C);
    wr(TMF_OFF_MASK, 32'h04);
    irqc(1'b1);
    wr(TMF_OFF_MASK, 32'h00);
    irqc(1'b0);
    // unmapped address
    apb(1'b0, 8'hE1, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    tally_and_finish();
  end
endmodule : tb
